// >>> ubt_pkg.sv
// shared constants for the break count and branch trace block
package ubt_pkg;

  // ==========================================================
  // register byte offsets on the apb bus
  localparam logic [7:0] ADDR_COUNT = 8'h00;
  localparam logic [7:0] ADDR_SOURCE = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // ==========================================================
  // field layout
  localparam int BREAK_COUNT_W = 12;
  localparam int COUNT_REG_W = 16;
  localparam int SRC_ADDR_W = 28;
  localparam int SRC_VALID_BIT = 31;
  localparam int SRC_QUEUE_DEPTH = 8;
  localparam int CTRL_COUNT_EN_BIT = 0;
  localparam int CTRL_TRACE_EN_BIT = 1;
  localparam int CTRL_W = 2;
  localparam int EVT_BREAK_BIT = 0;
  localparam int EVT_BRANCH_BIT = 1;
  localparam int EVT_W = 2;

  // ==========================================================
  // reset values
  localparam logic [BREAK_COUNT_W-1:0] COUNT_RESET = 12'h000;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
  localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

endpackage : ubt_pkg

// >>> ubt_count_break.sv
// execution count down-counter for channel b breaks
`timescale 1ns/1ps
module ubt_count_break
  import ubt_pkg::*;
#(
  parameter int CNT_W = BREAK_COUNT_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // software load
  input wire logic wr_en,
  input wire logic [CNT_W-1:0] wr_data,
  // break control
  input wire logic count_break_enable,
  input wire logic chb_match,
  // results
  output logic [CNT_W-1:0] count,
  output logic break_req
);

  if (CNT_W < 1 || CNT_W > COUNT_REG_W) begin : g_chk
    $error("ubt_count_break: CNT_W out of range");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic brk;
  } ubt_cnt_state_t;

  ubt_cnt_state_t s_r;
  ubt_cnt_state_t s_nxt;

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    // disabled counting breaks on every match, enabled only at one
    s_nxt.brk = chb_match & (~count_break_enable | (s_r.cnt == CNT_W'(1)));
    if (wr_en) begin
      s_nxt.cnt = wr_data;
    end else if (chb_match && count_break_enable && s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count = s_r.cnt;
  assign break_req = s_r.brk;

  // ==========================================================
  // checks
  property p_break_at_one;
    @(posedge pclk) disable iff (!presetn)
      chb_match && count_break_enable && s_r.cnt == CNT_W'(1) |=> break_req;
  endproperty
  a_break_at_one: assert property (p_break_at_one) else $error("no break at count one");

  property p_no_early_break;
    @(posedge pclk) disable iff (!presetn)
      count_break_enable && s_r.cnt != CNT_W'(1) |=> !break_req;
  endproperty
  a_no_early_break: assert property (p_no_early_break) else $error("break before count one");

  property p_decrement;
    @(posedge pclk) disable iff (!presetn)
      chb_match && count_break_enable && !wr_en && s_r.cnt != '0
        |=> count == $past(count) - CNT_W'(1);
  endproperty
  a_decrement: assert property (p_decrement) else $error("count did not decrement");

  property p_disabled_direct;
    @(posedge pclk) disable iff (!presetn)
      chb_match && !count_break_enable && !wr_en |=> break_req && count == $past(count);
  endproperty
  a_disabled_direct: assert property (p_disabled_direct) else $error("disabled match wrong");

endmodule : ubt_count_break

// >>> ubt_branch_queue.sv
// eight-deep queue of branch source records with valid flags
`timescale 1ns/1ps
module ubt_branch_queue
  import ubt_pkg::*;
#(
  parameter int DEPTH = SRC_QUEUE_DEPTH,
  parameter int AW = SRC_ADDR_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic push,
  input wire logic [AW-1:0] push_addr,
  input wire logic pop,
  input wire logic clear_all,
  // newest entry
  output logic head_valid,
  output logic [AW-1:0] head_addr
);

  if (DEPTH < 2 || AW < 1 || AW > SRC_ADDR_W) begin : g_chk
    $error("ubt_branch_queue: bad DEPTH or AW");
  end

  typedef struct packed {
    logic [DEPTH-1:0] vld;
  } ubt_q_state_t;

  ubt_q_state_t s_r;
  ubt_q_state_t s_nxt;
  // addresses carry no reset: they are meaningless until a branch lands
  logic [AW-1:0] mem [DEPTH];

  // ==========================================================
  // valid flags
  always_comb begin
    s_nxt = s_r;
    if (clear_all) begin
      s_nxt.vld = '0;
    end
    if (push && pop) begin
      s_nxt.vld[0] = 1'b1;
    end else if (push) begin
      s_nxt.vld = {s_nxt.vld[DEPTH-2:0], 1'b1};
    end else if (pop) begin
      s_nxt.vld = {1'b0, s_nxt.vld[DEPTH-1:1]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // address storage, shifted on every recorded branch except one that lands with a read
  always_ff @(posedge pclk) begin
    if (push && pop) begin
      mem[0] <= push_addr;
    end else if (push) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        mem[i] <= mem[i-1];
      end
      mem[0] <= push_addr;
    end else if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        mem[i] <= mem[i+1];
      end
    end
  end

  assign head_valid = s_r.vld[0];
  assign head_addr = mem[0];

  // ==========================================================
  // checks
  property p_push_valid;
    @(posedge pclk) disable iff (!presetn)
      push |=> head_valid && head_addr == $past(push_addr);
  endproperty
  a_push_valid: assert property (p_push_valid) else $error("push not recorded");

  property p_shift;
    @(posedge pclk) disable iff (!presetn)
      push && !pop && !clear_all |=> s_r.vld[1] == $past(s_r.vld[0]);
  endproperty
  a_shift: assert property (p_shift) else $error("queue did not shift");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      clear_all && !push |=> s_r.vld == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("valid flags not cleared");

  property p_pop;
    @(posedge pclk) disable iff (!presetn)
      pop && !push && !clear_all |=> s_r.vld == {1'b0, $past(s_r.vld[DEPTH-1:1])};
  endproperty
  a_pop: assert property (p_pop) else $error("read did not retire head");

endmodule : ubt_branch_queue

// >>> ubt_break_trace.sv
// apb top: execution count break and branch source trace
//
// Behaviour
// - count register is 16 bits; low twelve hold match count, reset zero
// - enabled count break: each channel b match decrements a nonzero count by one; zero holds
// - break requested on an enabled match only while count already holds one; with the enable at zero every match breaks
// - reserved bits read zero; software writes zero to them
// - branch source register is 32-bit read-only; writes change nothing
// - each entry captures low 28 bits of branching instruction address
// - bit 31 is valid flag, set when a branch is recorded
// - valid flag clears on read, on trace enable, on reset
// - captured address bits are not reset
// - eight-deep queue shifts by one on every recorded branch not landing with a source read
// - count break applies only to channel b while its enable is one
`timescale 1ns/1ps
module ubt_break_trace
  import ubt_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu events
  input wire logic chb_match,
  input wire logic branch_taken,
  input wire logic [APB_DW-1:0] branch_src_addr,
  // requests
  output logic user_break_req,
  output logic irq
);

  typedef struct packed {
    logic [APB_DW-1:0] rdata;
    logic ready;
    logic err;
    logic [CTRL_W-1:0] ctrl;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;
    logic irq;
  } ubt_top_state_t;

  ubt_top_state_t s_r;
  ubt_top_state_t s_nxt;

  logic [BREAK_COUNT_W-1:0] count;
  logic head_valid;
  logic [SRC_ADDR_W-1:0] head_addr;
  logic setup;
  logic wr_acc;
  logic cnt_wr;
  logic src_pop;
  logic trace_clear;
  logic push_en;
  logic status_rd;
  logic [CTRL_W-1:0] ctrl_wdata;

  function automatic logic mapped(input logic [APB_AW-1:0] a);
    return a == ADDR_COUNT || a == ADDR_SOURCE || a == ADDR_CTRL ||
           a == ADDR_STATUS || a == ADDR_MASK;
  endfunction : mapped

  // ==========================================================
  // bus decode
  // reads and their side effects are taken at the setup edge so the
  // returned word and the pop happen atomically; pready follows at once
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & s_r.ready & pwrite & ~s_r.err;
  assign cnt_wr = wr_acc & (paddr == ADDR_COUNT);
  assign src_pop = setup & ~pwrite & (paddr == ADDR_SOURCE);
  assign ctrl_wdata = pwdata[CTRL_W-1:0];
  // only a rising trace enable clears the queue
  assign trace_clear = wr_acc & (paddr == ADDR_CTRL) &
                       ctrl_wdata[CTRL_TRACE_EN_BIT] & ~s_r.ctrl[CTRL_TRACE_EN_BIT];
  // branches are recorded only while tracing is on
  assign push_en = branch_taken & s_r.ctrl[CTRL_TRACE_EN_BIT];
  assign status_rd = setup & ~pwrite & (paddr == ADDR_STATUS);

  // ==========================================================
  // sub-blocks
  ubt_count_break #(
    .CNT_W(BREAK_COUNT_W)
  ) u_count (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(cnt_wr),
    .wr_data(pwdata[BREAK_COUNT_W-1:0]),
    .count_break_enable(s_r.ctrl[CTRL_COUNT_EN_BIT]),
    .chb_match(chb_match),
    .count(count),
    .break_req(user_break_req)
  );

  ubt_branch_queue #(
    .DEPTH(SRC_QUEUE_DEPTH),
    .AW(SRC_ADDR_W)
  ) u_queue (
    .pclk(pclk),
    .presetn(presetn),
    .push(push_en),
    .push_addr(branch_src_addr[SRC_ADDR_W-1:0]),
    .pop(src_pop),
    .clear_all(trace_clear),
    .head_valid(head_valid),
    .head_addr(head_addr)
  );

  // ==========================================================
  // register file and interrupt
  always_comb begin
    logic [EVT_W-1:0] evt;
    evt = '0;
    s_nxt = s_r;
    evt[EVT_BREAK_BIT] = user_break_req;
    evt[EVT_BRANCH_BIT] = push_en;
    s_nxt.ready = setup;
    // err drops after the access so pslverr is a plain flop
    s_nxt.err = 1'b0;
    if (setup) begin
      s_nxt.err = ~mapped(paddr);
      s_nxt.rdata = '0;
      if (!pwrite) begin
        unique case (paddr)
          ADDR_COUNT: s_nxt.rdata[BREAK_COUNT_W-1:0] = count;
          ADDR_SOURCE: begin
            s_nxt.rdata[SRC_VALID_BIT] = head_valid;
            s_nxt.rdata[SRC_ADDR_W-1:0] = head_addr;
          end
          ADDR_CTRL: s_nxt.rdata[CTRL_W-1:0] = s_r.ctrl;
          ADDR_STATUS: s_nxt.rdata[EVT_W-1:0] = s_r.status;
          ADDR_MASK: s_nxt.rdata[EVT_W-1:0] = s_r.mask;
          default: s_nxt.rdata = '0;
        endcase
      end
    end
    if (status_rd) begin
      s_nxt.status = '0;
    end
    // a new event in the clearing cycle survives
    s_nxt.status = s_nxt.status | evt;
    if (wr_acc && paddr == ADDR_CTRL) begin
      s_nxt.ctrl = ctrl_wdata;
    end
    if (wr_acc && paddr == ADDR_MASK) begin
      s_nxt.mask = pwdata[EVT_W-1:0];
    end
    // writes to the source register fall through untouched
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{rdata: '0, ready: 1'b0, err: 1'b0, ctrl: CTRL_RESET,
               status: EVT_RESET, mask: EVT_RESET, irq: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.err;
  assign irq = s_r.irq;

  // ==========================================================
  // checks
  property p_count_reserved;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == ADDR_COUNT |=> prdata[COUNT_REG_W-1:BREAK_COUNT_W] == '0;
  endproperty
  a_count_reserved: assert property (p_count_reserved) else $error("count reserved bits set");

  property p_src_reserved;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == ADDR_SOURCE
        |=> prdata[SRC_VALID_BIT-1:SRC_ADDR_W] == '0 && prdata[SRC_VALID_BIT] == $past(head_valid);
  endproperty
  a_src_reserved: assert property (p_src_reserved) else $error("source read wrong");

  property p_src_readonly;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == ADDR_SOURCE && !branch_taken
        |=> head_valid == $past(head_valid) && head_addr == $past(head_addr);
  endproperty
  a_src_readonly: assert property (p_src_readonly) else $error("source register written");

  property p_read_clears;
    @(posedge pclk) disable iff (!presetn)
      src_pop && !push_en && !head_valid |=> !head_valid;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read revived empty queue");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      irq == |(s_r.status & s_r.mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq does not follow status");

  property p_trace_clear;
    @(posedge pclk) disable iff (!presetn)
      trace_clear |=> !head_valid;
  endproperty
  a_trace_clear: assert property (p_trace_clear) else $error("trace enable kept entry");

  property p_trace_off;
    @(posedge pclk) disable iff (!presetn)
      branch_taken && !s_r.ctrl[CTRL_TRACE_EN_BIT] && !src_pop && !trace_clear
        |=> head_valid == $past(head_valid);
  endproperty
  a_trace_off: assert property (p_trace_off) else $error("branch traced while off");

  property p_push_record;
    @(posedge pclk) disable iff (!presetn)
      push_en |=> head_valid && head_addr == $past(branch_src_addr[SRC_ADDR_W-1:0]);
  endproperty
  a_push_record: assert property (p_push_record) else $error("branch not recorded");

  property p_src_addr_read;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == ADDR_SOURCE && head_valid
        |=> prdata[SRC_ADDR_W-1:0] == $past(head_addr);
  endproperty
  a_src_addr_read: assert property (p_src_addr_read) else $error("source address wrong");

  property p_count_read;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == ADDR_COUNT |=> prdata[BREAK_COUNT_W-1:0] == $past(count);
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read wrong");

  property p_count_write;
    @(posedge pclk) disable iff (!presetn)
      cnt_wr |=> count == $past(pwdata[BREAK_COUNT_W-1:0]);
  endproperty
  a_count_write: assert property (p_count_write) else $error("count write lost");

  // ==========================================================
  // bus handshake and register file checks
  property p_ready_after_setup;
    @(posedge pclk) disable iff (!presetn)
      setup |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

  property p_err_unmapped;
    @(posedge pclk) disable iff (!presetn)
      setup && !mapped(paddr) |=> pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

  property p_err_mapped;
    @(posedge pclk) disable iff (!presetn)
      setup && mapped(paddr) |=> !pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");

  property p_err_with_ready;
    @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

  property p_unmapped_zero;
    @(posedge pclk) disable iff (!presetn)
      setup && !mapped(paddr) |=> prdata == '0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_rdata_hold;
    @(posedge pclk) disable iff (!presetn)
      !setup |=> $stable(prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_ctrl_write;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == ADDR_CTRL |=> s_r.ctrl == $past(ctrl_wdata);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  property p_mask_write;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == ADDR_MASK |=> s_r.mask == $past(pwdata[EVT_W-1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_ctrl_read;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == ADDR_CTRL |=> prdata[CTRL_W-1:0] == $past(s_r.ctrl);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

  property p_status_rdata;
    @(posedge pclk) disable iff (!presetn)
      status_rd |=> prdata[EVT_W-1:0] == $past(s_r.status);
  endproperty
  a_status_rdata: assert property (p_status_rdata) else $error("status read wrong");

  property p_mask_rdata;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == ADDR_MASK |=> prdata[EVT_W-1:0] == $past(s_r.mask);
  endproperty
  a_mask_rdata: assert property (p_mask_rdata) else $error("mask read wrong");

  property p_status_clear;
    @(posedge pclk) disable iff (!presetn)
      status_rd && !user_break_req && !push_en |=> s_r.status == '0;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared by read");

  property p_status_sticky;
    @(posedge pclk) disable iff (!presetn)
      !status_rd
        |=> (s_r.status & $past(s_r.status)) == $past(s_r.status);
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status bit lost");

  property p_branch_status;
    @(posedge pclk) disable iff (!presetn)
      push_en |=> s_r.status[EVT_BRANCH_BIT];
  endproperty
  a_branch_status: assert property (p_branch_status) else $error("branch event lost");

  property p_break_sets_status;
    @(posedge pclk) disable iff (!presetn)
      user_break_req |=> s_r.status[EVT_BREAK_BIT];
  endproperty
  a_break_sets_status: assert property (p_break_sets_status) else $error("break lost");

endmodule : ubt_break_trace

// >>> ubt_cpu_model.sv
// far-side model: cpu break-match and branch event source
`timescale 1ns/1ps
module ubt_cpu_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // commands from the bench
  input wire logic req_match,
  input wire logic req_branch,
  input wire logic [31:0] req_addr,
  // event outputs
  output logic chb_match,
  output logic branch_taken,
  output logic [31:0] branch_src_addr
);
  // ==========================================================
  // events
  // address means nothing without branch_taken; scramble it so nothing leans on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chb_match <= 1'b0;
      branch_taken <= 1'b0;
      branch_src_addr <= 32'h0000_0000;
    end else begin
      chb_match <= req_match;
      branch_taken <= req_branch;
      branch_src_addr <= req_branch ? req_addr : ~branch_src_addr;
    end
  end
endmodule : ubt_cpu_model

// >>> tb_top.sv
// self-checking bench for the break count and branch trace block
`timescale 1ns/1ps
module tb_top;
  import ubt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, req_addr = 32'h0, branch_src_addr, rd;
  logic pready, pslverr, chb_match, branch_taken, user_break_req, irq, er, brk;
  logic req_match = 1'b0, req_branch = 1'b0;
  logic [27:0] q[$];
  int error_cnt = 0, samples_checked = 0, n, i;
  integer seed = 35205;

  always #2.5 pclk = ~pclk;

  ubt_cpu_model cpu (.pclk(pclk), .presetn(presetn), .req_match(req_match),
    .req_branch(req_branch), .req_addr(req_addr), .chb_match(chb_match),
    .branch_taken(branch_taken), .branch_src_addr(branch_src_addr));

  ubt_break_trace dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chb_match(chb_match), .branch_taken(branch_taken),
    .branch_src_addr(branch_src_addr), .user_break_req(user_break_req), .irq(irq));

  // ==========================================================
  // helpers
  function automatic logic [31:0] src_word(input logic [27:0] a);
    return {1'b1, 3'h0, a};
  endfunction : src_word

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic chk_flag(input string nm, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
      error_cnt++;
    end
  endtask : chk_flag

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic ev(output logic b);
    @(posedge pclk);
    req_match <= 1'b1;
    @(posedge pclk);
    req_match <= 1'b0;
    @(posedge pclk);
    #1;
    b = user_break_req;
  endtask : ev

  // back-to-back branches, one per cycle, to stress the shifting
  task automatic burst(input int k);
    logic [31:0] a;
    repeat (k) begin
      @(posedge pclk);
      a = $random(seed);
      req_branch <= 1'b1;
      req_addr <= a;
      q.push_front(a[27:0]);
      if (q.size() > SRC_QUEUE_DEPTH) begin
        void'(q.pop_back());
      end
    end
    @(posedge pclk);
    req_branch <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : burst

  task automatic tally_and_finish;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    tally_and_finish();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_COUNT, 32'h0, rd, er);
    chk("count_rst", 32'h0, rd);
    chk_flag("count_err", 1'b0, er);
    apb(1'b0, ADDR_SOURCE, 32'h0, rd, er);
    chk("src_rst_flag", 32'h0, rd & 32'hf000_0000);
    apb(1'b0, 8'h20, 32'h0, rd, er);
    chk_flag("unmapped_err", 1'b1, er);
    chk("unmapped_data", 32'h0, rd);
    apb(1'b1, ADDR_COUNT, 32'h0000_0fff, rd, er);
    apb(1'b0, ADDR_COUNT, 32'h0, rd, er);
    chk("count_resv", 32'h0000_0fff, rd);
    apb(1'b1, ADDR_MASK, 32'h3, rd, er);
    apb(1'b1, ADDR_CTRL, 32'h1, rd, er);
    apb(1'b0, ADDR_CTRL, 32'h0, rd, er);
    chk("ctrl_rd", 32'h1, rd);
    ev(brk);
    chk_flag("max_no_break", 1'b0, brk);
    apb(1'b0, ADDR_COUNT, 32'h0, rd, er);
    chk("max_dec", 32'h0000_0ffe, rd);
    n = 1 + ($unsigned($random(seed)) % 6);
    apb(1'b1, ADDR_COUNT, 32'(n), rd, er);
    for (i = n; i >= 0; i--) begin
      ev(brk);
      chk_flag("break_req", i == 1, brk);
      apb(1'b0, ADDR_COUNT, 32'h0, rd, er);
      chk("count_dec", 32'((i > 0) ? i - 1 : 0), rd);
    end
    chk_flag("irq_set", 1'b1, irq);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk("status_brk", 32'h1, rd);
    @(posedge pclk);
    #1;
    chk_flag("irq_clr", 1'b0, irq);
    apb(1'b1, ADDR_CTRL, 32'h0, rd, er);
    apb(1'b1, ADDR_COUNT, 32'h3, rd, er);
    ev(brk);
    chk_flag("direct_break", 1'b1, brk);
    apb(1'b0, ADDR_COUNT, 32'h0, rd, er);
    chk("count_held", 32'h3, rd);
    burst(2);
    q.delete();
    apb(1'b1, ADDR_CTRL, 32'h2, rd, er);
    burst(10);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk("status_both", 32'h3, rd);
    apb(1'b1, ADDR_SOURCE, 32'h0, rd, er);
    for (i = 0; i < 9; i++) begin
      apb(1'b0, ADDR_SOURCE, 32'h0, rd, er);
      if (q.size() > 0) begin
        chk("src_entry", src_word(q.pop_front()), rd);
      end else begin
        chk("src_empty", 32'h0, rd & 32'hf000_0000);
      end
    end
    burst(3);
    apb(1'b1, ADDR_CTRL, 32'h0, rd, er);
    apb(1'b1, ADDR_CTRL, 32'h2, rd, er);
    q.delete();
    apb(1'b0, ADDR_SOURCE, 32'h0, rd, er);
    chk("src_trace_clr", 32'h0, rd & 32'hf000_0000);
    apb(1'b1, ADDR_MASK, 32'h0, rd, er);
    ev(brk);
    chk_flag("direct_break_trace", 1'b1, brk);
    apb(1'b0, ADDR_MASK, 32'h0, rd, er);
    chk("mask_rd", 32'h0, rd);
    chk_flag("irq_masked", 1'b0, irq);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk("status_masked", 32'h3, rd);
    tally_and_finish();
  end
endmodule : tb_top
